// file: rtl/rxa_pkg.sv
// Constants for the receive frame admission block
package rxa_pkg;
	localparam logic [11:0] RECEIVE_CONTROL_ONE_ADDR = 12'h0174;
	localparam logic [15:0] RECEIVE_CONTROL_ONE_RST = 16'h0800;
	localparam logic [15:0] RECEIVE_CONTROL_ONE_MASK = 16'hFF01;
	localparam int RX_QUEUE_FLUSH_BIT = 15;
	localparam int RX_UDP_SUM_CHECK_EN_BIT = 14;
	localparam int RX_TCP_SUM_CHECK_EN_BIT = 13;
	localparam int RX_IP_SUM_CHECK_EN_BIT = 12;
	localparam int RX_UNICAST_FILTER_EN_BIT = 11;
	localparam int RX_PAUSE_HONOUR_EN_BIT = 10;
	localparam int RX_CRC_ERROR_ADMIT_BIT = 9;
	localparam int RX_MULTICAST_FILTER_EN_BIT = 8;
	localparam int RX_RUN_ENABLE_BIT = 0;
	// One pause quantum is 512 bit times at 100 Mb/s
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PAUSE_QUANTUM_PS = 5120000;
	localparam int PAUSE_QUANTUM_CYC = (PAUSE_QUANTUM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0] PAUSE_QUANTUM_LAST = 8'(PAUSE_QUANTUM_CYC - 1);
	localparam int QUEUE_DEPTH = 64;
	typedef enum logic [2:0] {
		RXA_STOP = 3'b001,
		RXA_RUN = 3'b010,
		RXA_DRAIN = 3'b100
	} rxa_state_t;
endpackage

// file: rtl/rxa_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module rxa_skid_buf #(
	parameter int WIDTH = 9
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot1_r;
	logic [1:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != 2'd2);
	assign out_valid = (count_r != 2'd0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (!rst_n || clear) begin
			count_r <= 2'd0;
		end else begin
			count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
		end
	end

	// Head slot reloads from the second slot on a pop so order is kept
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			out_data <= '0;
			slot1_r <= '0;
		end else begin
			if (pop && count_r == 2'd2) begin
				out_data <= slot1_r;
			end else if (push && (count_r == 2'd0 || (pop && count_r == 2'd1))) begin
				out_data <= in_data;
			end
			if (push && ((count_r == 2'd1 && !pop) || count_r == 2'd2)) begin
				slot1_r <= in_data;
			end
		end
	end
endmodule // rxa_skid_buf

// file: rtl/rxa_admission.sv
// Receive frame admission, queue, flush and pause handling
//
// Operation
// - While flush bit is set, queue and frame pointers and the output buffer are cleared; queue memory keeps its contents.
// - UDP check enabled: frames with bad UDP checksum are discarded.
// - TCP check enabled: frames with bad TCP checksum are discarded.
// - IP check enabled: frames with bad IP header checksum are discarded.
// - Unicast filter enable resets to one; admits unicast frames passing address filter.
// - Pause honour in full duplex holds transmit until pause timer expires.
// - CRC admit set keeps CRC-error frames; cleared discards them.
// - Multicast filter enable admits multicast frames passing the address filter.
// - Run enable starts reception; clearing stops after the current frame.
`timescale 1ns/100ps
module rxa_admission #(
	parameter int DEPTH = rxa_pkg::QUEUE_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [11:0] host_addr,
	input wire logic host_wr,
	input wire logic [15:0] host_wdata,
	input wire logic host_rd,
	output logic [15:0] host_rdata,
	input wire logic full_duplex,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	input wire logic in_multicast,
	input wire logic in_addr_pass,
	input wire logic in_ip,
	input wire logic in_ip_bad,
	input wire logic in_tcp,
	input wire logic in_tcp_bad,
	input wire logic in_udp,
	input wire logic in_udp_bad,
	input wire logic in_crc_err,
	input wire logic in_pause,
	input wire logic [15:0] in_pause_quanta,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data,
	output logic out_last,
	output logic tx_hold,
	output logic rx_running
);
	import rxa_pkg::*;

	localparam int PW = $clog2(DEPTH) + 1;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

	logic [15:0] ctrl_r;
	rxa_state_t state_r;
	logic in_frame_r;
	logic drop_r;
	logic [8:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] cm_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [15:0] quanta_r;
	logic [7:0] presc_r;
	logic flush;
	logic run_en;
	logic acc;
	logic drop_now;
	logic q_full;
	logic q_empty;
	logic admit_ok;
	logic addr_ok;
	logic commit;
	logic pause_load;
	logic buf_ready;
	logic [8:0] buf_out;

	assign flush = ctrl_r[RX_QUEUE_FLUSH_BIT];
	assign run_en = ctrl_r[RX_RUN_ENABLE_BIT];

	// Register port; bits outside this block's scope read as zero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_r <= RECEIVE_CONTROL_ONE_RST;
		end else if (host_wr && host_addr == RECEIVE_CONTROL_ONE_ADDR) begin
			ctrl_r <= host_wdata & RECEIVE_CONTROL_ONE_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			host_rdata <= 16'h0000;
		end else if (host_rd) begin
			host_rdata <= (host_addr == RECEIVE_CONTROL_ONE_ADDR) ? ctrl_r : 16'h0000;
		end
	end

	// A frame that starts while stopped or flushing is consumed but never stored
	assign drop_now = in_frame_r ? drop_r : (state_r == RXA_STOP || flush);
	assign q_full = (PW'(wr_ptr_r - rd_ptr_r) == DEPTH_P);
	assign q_empty = (rd_ptr_r == cm_ptr_r);
	assign in_ready = drop_now || flush || !q_full;
	assign acc = in_valid && in_ready;

	assign addr_ok = in_addr_pass && (in_multicast ? ctrl_r[RX_MULTICAST_FILTER_EN_BIT]
		: ctrl_r[RX_UNICAST_FILTER_EN_BIT]);

	assign admit_ok = addr_ok && !in_pause
		&& !(in_crc_err && !ctrl_r[RX_CRC_ERROR_ADMIT_BIT])
		&& !(in_udp && in_udp_bad && ctrl_r[RX_UDP_SUM_CHECK_EN_BIT])
		&& !(in_tcp && in_tcp_bad && ctrl_r[RX_TCP_SUM_CHECK_EN_BIT])
		&& !(in_ip && in_ip_bad && ctrl_r[RX_IP_SUM_CHECK_EN_BIT]);

	assign commit = acc && in_last && !drop_now && !flush && admit_ok;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= RXA_STOP;
		end else begin
			unique case (state_r)
				RXA_STOP: begin
					if (run_en) begin
						state_r <= RXA_RUN;
					end
				end
				RXA_RUN: begin
					if (!run_en) begin
						// A frame whose first byte is taken this cycle is also finished first
						state_r <= (acc ? !in_last : in_frame_r) ? RXA_DRAIN : RXA_STOP;
					end
				end
				RXA_DRAIN: begin
					if (acc && in_last) begin
						state_r <= run_en ? RXA_RUN : RXA_STOP;
					end
				end
				default: begin
					state_r <= RXA_STOP;
				end
			endcase
		end
	end
	assign rx_running = (state_r != RXA_STOP);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			in_frame_r <= 1'b0;
			drop_r <= 1'b0;
		end else if (acc) begin
			in_frame_r <= !in_last;
			drop_r <= drop_now || flush;
		end else if (flush) begin
			drop_r <= 1'b1;
		end
	end

	// flush clears pointers; a frame caught mid-way is dropped
	always_ff @(posedge core_clk) begin
		if (!rst_n || flush) begin
			wr_ptr_r <= '0;
			cm_ptr_r <= '0;
		end else if (commit) begin
			wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
			cm_ptr_r <= PW'(wr_ptr_r + 1'b1);
		end else if (acc && !drop_now) begin
			if (!in_last) begin
				wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
			end else begin
				wr_ptr_r <= cm_ptr_r;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (acc && !drop_now) begin
			mem_r[wr_ptr_r[PW-2:0]] <= {in_last, in_data};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n || flush) begin
			rd_ptr_r <= '0;
		end else if (!q_empty && buf_ready) begin
			rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
		end
	end

	// Buffer absorbs a stall by the host without losing the word in flight
	rxa_skid_buf #(.WIDTH(9)) u_buf (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(flush),
		.in_valid(!q_empty),
		.in_ready(buf_ready),
		.in_data(mem_r[rd_ptr_r[PW-2:0]]),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(buf_out)
	);
	assign out_data = buf_out[7:0];
	assign out_last = buf_out[8];

	// pause honoured only in full duplex, only from clean frames
	assign pause_load = acc && in_last && in_pause && !drop_now && !in_crc_err
		&& ctrl_r[RX_PAUSE_HONOUR_EN_BIT] && full_duplex;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			quanta_r <= 16'h0000;
			presc_r <= 8'h00;
		end else if (pause_load) begin
			quanta_r <= in_pause_quanta;
			presc_r <= 8'h00;
		end else if (quanta_r != 16'h0000) begin
			if (presc_r == PAUSE_QUANTUM_LAST) begin
				presc_r <= 8'h00;
				quanta_r <= quanta_r - 16'h0001;
			end else begin
				presc_r <= presc_r + 8'h01;
			end
		end
	end
	assign tx_hold = (quanta_r != 16'h0000);

	sequence last_word_s;
		acc && in_last && !drop_now && !flush;
	endsequence

	sequence kept_s;
		cm_ptr_r == $past(cm_ptr_r);
	endsequence

	flush_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		flush |=> (cm_ptr_r == '0 && rd_ptr_r == '0 && !out_valid)) else $error("flush left queue data");
	udp_discard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		last_word_s and (ctrl_r[RX_UDP_SUM_CHECK_EN_BIT] && in_udp && in_udp_bad) |=> kept_s)
		else $error("bad UDP frame admitted");
	tcp_discard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		last_word_s and (ctrl_r[RX_TCP_SUM_CHECK_EN_BIT] && in_tcp && in_tcp_bad) |=> kept_s)
		else $error("bad TCP frame admitted");
	ip_discard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		last_word_s and (ctrl_r[RX_IP_SUM_CHECK_EN_BIT] && in_ip && in_ip_bad) |=> kept_s)
		else $error("bad IP frame admitted");
	unicast_admit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		last_word_s and (!in_multicast && in_addr_pass && !in_pause && !in_crc_err && !in_ip && !in_tcp
		&& !in_udp && ctrl_r[RX_UNICAST_FILTER_EN_BIT]) |=> cm_ptr_r == PW'($past(wr_ptr_r) + 1'b1))
		else $error("good unicast frame dropped");
	pause_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		pause_load && in_pause_quanta != 16'h0000 |=> tx_hold [*8]) else $error("pause not held");
	crc_discard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		last_word_s and (in_crc_err && !ctrl_r[RX_CRC_ERROR_ADMIT_BIT]) |=> kept_s)
		else $error("CRC error frame admitted");
	multicast_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		last_word_s and (in_multicast && !ctrl_r[RX_MULTICAST_FILTER_EN_BIT]) |=> kept_s)
		else $error("multicast admitted while disabled");
	drain_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_r == RXA_DRAIN && acc && in_last && !run_en |=> state_r == RXA_STOP && !rx_running)
		else $error("receive did not stop after frame");
	frame_whole_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		acc && !in_last && !flush |=> kept_s) else $error("partial frame committed");
endmodule // rxa_admission

// file: sim/rxa_drain_model.sv
// Host model that drains the receive queue
`timescale 1ns/100ps
module rxa_drain_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	output logic out_ready
);
	logic [7:0] lfsr_r;
	// Mode 0 takes every byte, 1 stalls at random, 2 stalls outright
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			lfsr_r <= 8'h5A;
			out_ready <= 1'b0;
		end else begin
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
			out_ready <= (mode == 2'd0) || (mode == 2'd1 && lfsr_r[0]);
		end
	end
endmodule // rxa_drain_model

// file: sim/tb.sv
// Self-checking bench for the receive admission block
`timescale 1ns/100ps
module tb;
	import rxa_pkg::*;
	logic core_clk, rst_n, host_wr, host_rd, full_duplex, in_valid, in_ready, in_last;
	logic out_valid, out_ready, out_last, tx_hold, rx_running;
	logic [11:0] host_addr;
	logic [15:0] host_wdata, host_rdata, quanta;
	logic [7:0] in_data, out_data;
	logic [9:0] fl;
	logic [1:0] mode;
	logic [31:0] seed, r;
	logic [15:0] c;
	logic [9:0] f;
	logic [15:0] exp_q[$];
	int err_total, checks;
	rxa_admission #(.DEPTH(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr),
		.host_wr(host_wr), .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
		.full_duplex(full_duplex), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.in_last(in_last), .in_multicast(fl[9]), .in_addr_pass(fl[8]), .in_ip(fl[7]), .in_ip_bad(fl[6]),
		.in_tcp(fl[5]), .in_tcp_bad(fl[4]), .in_udp(fl[3]), .in_udp_bad(fl[2]), .in_crc_err(fl[1]),
		.in_pause(fl[0]), .in_pause_quanta(quanta), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data), .out_last(out_last), .tx_hold(tx_hold), .rx_running(rx_running));
	rxa_drain_model host (.core_clk(core_clk), .rst_n(rst_n), .mode(mode), .out_ready(out_ready));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic bit adm(logic [15:0] k, logic [9:0] g);
		if (g[0] || !g[8] || !(g[9] ? k[8] : k[11])) return 0;
		if ((k[14] && g[2]) || (k[13] && g[4]) || (k[12] && g[6]) || (!k[9] && g[1])) return 0;
		return k[0];
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [15:0] d);
		host_addr <= 12'h0174;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge core_clk);
		host_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge core_clk);
		host_rd <= 1'b0;
		@(negedge core_clk);
		chk(host_rdata, e);
		@(posedge core_clk);
	endtask
	task automatic send(input int n, input logic [9:0] g, input bit keep);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			r = xs();
			b = r[7:0];
			if (keep) exp_q.push_back({7'b0, i == n - 1, b});
			in_valid <= 1'b1;
			in_data <= b;
			in_last <= (i == n - 1);
			fl <= g;
			do @(negedge core_clk); while (in_ready !== 1'b1);
			@(posedge core_clk);
		end
		in_valid <= 1'b0;
		in_last <= 1'b0;
		// One idle edge so a following frame never drives in_valid twice at once
		@(posedge core_clk);
	endtask
	task automatic drain();
		for (int t = 0; t < 600 && exp_q.size() != 0; t++) @(posedge core_clk);
		chk(exp_q.size(), 0);
	endtask
	always @(posedge core_clk) begin
		if (rst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) chk(16'hFFFF, 16'h0000);
			else chk({7'b0, out_last, out_data}, exp_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		give_verdict();
	end
	initial begin
		{rst_n, host_wr, host_rd, in_valid, in_last, in_data, fl, quanta, mode} = '0;
		{full_duplex, host_addr, host_wdata, err_total, checks, seed} = {1'b1, 28'h0, 64'h0, 32'ha015_8c78};
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(12'h0174, RECEIVE_CONTROL_ONE_RST);
		wr(16'h7FFF);
		rd(12'h0174, 16'h7F01);
		rd(12'h0176, 16'h0000);
		chk(rx_running, 1);
		mode <= 2'd1;
		for (int k = 0; k < 60; k++) begin
			r = xs();
			c = (r[15:0] & 16'h7B00) | 16'h0001;
			r = xs();
			f = r[9:0] & 10'h3FE;
			f[6] &= f[7];
			f[4] &= f[5];
			f[2] &= f[3];
			wr(c);
			send(1 + k % 6, f, adm(c, f));
		end
		drain();
		wr(16'h0800);
		repeat (4) @(posedge core_clk);
		chk(rx_running, 0);
		send(4, 10'h100, 0);
		wr(16'h0801);
		fork
			send(5, 10'h100, 1);
			begin
				repeat (2) @(posedge core_clk);
				wr(16'h0800);
			end
		join
		drain();
		mode <= 2'd2;
		wr(16'h0801);
		send(4, 10'h100, 0);
		// Run cleared before the flush, flush cleared afterwards
		wr(16'h0800);
		wr(16'h8800);
		@(negedge core_clk);
		chk(out_valid, 0);
		@(posedge core_clk);
		wr(16'h0801);
		mode <= 2'd0;
		send(3, 10'h100, 1);
		drain();
		mode <= 2'd2;
		fork
			begin
				send(6, 10'h100, 1);
				send(6, 10'h100, 1);
			end
			begin
				repeat (40) @(posedge core_clk);
				@(negedge core_clk);
				chk(in_ready, 0);
				@(posedge core_clk);
				mode <= 2'd1;
			end
		join
		drain();
		mode <= 2'd0;
		quanta <= 16'h0002;
		// Pause honour stays off while the port is half duplex
		full_duplex <= 1'b0;
		wr(16'h0001);
		send(1, 10'h301, 0);
		repeat (3) @(negedge core_clk);
		chk(tx_hold, 0);
		@(posedge core_clk);
		full_duplex <= 1'b1;
		send(1, 10'h301, 0);
		repeat (3) @(negedge core_clk);
		chk(tx_hold, 0);
		@(posedge core_clk);
		wr(16'h0401);
		send(1, 10'h301, 0);
		repeat (3) @(negedge core_clk);
		chk(tx_hold, 1);
		repeat (400) @(negedge core_clk);
		chk(tx_hold, 1);
		repeat (12) @(negedge core_clk);
		chk(tx_hold, 0);
		drain();
		give_verdict();
	end
endmodule // tb
